// ===== verilog/pdo_regs_pkg.sv
package pdo_regs_pkg;

  // =====================================================================
  // register indices
  localparam logic [3:0] IDX_FLOW_PSET   = 4'h0;
  localparam logic [3:0] IDX_AUTOSAVE    = 4'h1;
  localparam logic [3:0] IDX_PRESS_PSET  = 4'h2;
  localparam logic [3:0] IDX_ACCUM_FLOW  = 4'h3;
  localparam logic [3:0] IDX_FLOW_TARGET = 4'h4;
  localparam logic [3:0] IDX_BACKUP_CMD  = 4'h5;
  localparam logic [3:0] IDX_ERR_ACK     = 4'h6;
  localparam logic [3:0] IDX_CAL_SELECT  = 4'h7;
  localparam logic [3:0] IDX_VALVE_DRIVE = 4'h8;
  localparam logic [3:0] IDX_CTRL_MODE   = 4'h9;
  localparam logic [3:0] IDX_FAULT_FLAGS = 4'hA;

  // =====================================================================
  // codes
  localparam logic [15:0] PSET_USER1      = 16'h0000;
  localparam logic [15:0] PSET_USER2      = 16'h0001;
  localparam logic [15:0] PSET_FAST       = 16'h0002;
  localparam logic [15:0] PSET_MEDIUM     = 16'h0003;
  localparam logic [15:0] PSET_SLOW       = 16'h0004;
  localparam logic [15:0] SAVE_MANUAL     = 16'h0000;
  localparam logic [15:0] SAVE_AUTO       = 16'h0001;
  localparam logic [15:0] MODE_AUTO_SRC   = 16'h0000;
  localparam logic [15:0] MODE_DIGITAL    = 16'h0001;
  localparam logic [15:0] MODE_ANALOG     = 16'h0002;
  localparam logic [15:0] MODE_VALVE_MAN  = 16'h000A;
  localparam logic [31:0] CMD_BACKUP      = 32'h0000_0001;
  localparam logic [31:0] CMD_RESTORE     = 32'h0000_0002;
  localparam logic [31:0] CMD_REMOVE      = 32'h0000_0003;
  localparam logic [15:0] CAL_TABLES      = 16'h000A;
  localparam logic [31:0] VALVE_FULL      = 32'h0000_2710;

  // =====================================================================
  // reset values
  localparam logic [15:0] RST_PSET        = 16'h0000;
  localparam logic [15:0] RST_AUTOSAVE    = 16'h0000;
  localparam logic [15:0] RST_MODE        = 16'h0002;
  localparam logic [15:0] RST_CAL         = 16'h0000;
  localparam logic [31:0] RST_WORD        = 32'h0000_0000;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  idx;
    logic [31:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    BK_NONE,
    BK_BACKUP,
    BK_RESTORE,
    BK_REMOVE
  } backup_op_t;

endpackage

// ===== verilog/pdo_regs.sv
`timescale 1ns/1ns
`default_nettype none

// Contract
// - set select code 0 user1 default, 1 user2
// - codes 2,3,4 fast, medium, slow sets
// - pressure selector uses same codes as flow
// - autosave only acts in digital mode 1
// - storage option 0 manual, 1 automatic
// - target active only in mode 0 or 1
// - backup codes 1 make, 2 restore, 3 remove
// - backup, or restore while a backup exists, forces device reset
// - write one clears fault bit, zero keeps
// - fault bits set only by hardware conditions
// - acknowledged fault stays suppressed until restart
// - calibration select picks one of ten tables
// - valve register shows applied valve value
// - valve write applies in mode 10, else buffered
// - manual valve value spans zero to full
// - mode 10 drives valve from register
// - mode 0 switches to digital on set point
module pdo_regs
  import pdo_regs_pkg::*;
#(
  parameter int unsigned FAULT_W = 16
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire reg_req_t          req,
  output logic [31:0]            rdata,
  output logic                   rvalid,
  input  wire logic [FAULT_W-1:0] fault_detect,
  input  wire logic [31:0]       loop_valve,
  input  wire logic [31:0]       accum_in,
  output logic [2:0]             flow_pset,
  output logic [2:0]             press_pset,
  output logic [3:0]             cal_table,
  output logic [31:0]            target_out,
  output logic                   target_valid,
  output logic                   nv_store_pulse,
  output logic [31:0]            valve_out,
  output logic                   valve_manual,
  output logic                   dev_reset_pulse,
  output backup_op_t             startup_op,
  output logic                   backup_exists,
  output logic [FAULT_W-1:0]     fault_flags
);

  logic [15:0]        flow_param_set_select_r;
  logic [15:0]        pressure_param_set_select_r;
  logic [15:0]        setpoint_autosave_enable_r;
  logic [15:0]        calibration_table_select_r;
  logic [15:0]        ctrl_mode_r;
  logic [31:0]        flow_target_r;
  logic [31:0]        valve_buf_r;
  logic [31:0]        accum_r;
  logic               digital_src_r;
  logic [FAULT_W-1:0] suppress_r;
  logic [31:0]        valve_nxt;
  logic               wr_hit;

  function automatic logic wr_to(input reg_req_t r, input logic [3:0] i);
    return r.wr && (r.idx == i);
  endfunction

  // valid selector codes are 0..4
  function automatic logic [2:0] pset_code(input logic [15:0] v);
    return (v <= PSET_SLOW) ? v[2:0] : PSET_USER1[2:0];
  endfunction

  function automatic logic [31:0] clip_valve(input logic [31:0] v);
    return (v > VALVE_FULL) ? VALVE_FULL : v;
  endfunction

  assign wr_hit = req.wr;

  // =====================================================================
  // parameter set selectors
  always_ff @(posedge clk) begin
    if (srst) begin
      flow_param_set_select_r     <= RST_PSET;
      pressure_param_set_select_r <= RST_PSET;
    end else begin
      if (wr_to(req, IDX_FLOW_PSET) && req.wdata[15:0] <= PSET_SLOW) begin
        flow_param_set_select_r <= req.wdata[15:0];
      end
      if (wr_to(req, IDX_PRESS_PSET) && req.wdata[15:0] <= PSET_SLOW) begin
        pressure_param_set_select_r <= req.wdata[15:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      flow_pset  <= 3'd0;
      press_pset <= 3'd0;
    end else begin
      flow_pset  <= pset_code(flow_param_set_select_r);
      press_pset <= pset_code(pressure_param_set_select_r);
    end
  end

  // =====================================================================
  // controller mode
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_mode_r <= RST_MODE;
    end else begin
      if (wr_to(req, IDX_CTRL_MODE)) begin
        ctrl_mode_r <= req.wdata[15:0];
      end
    end
  end

  // =====================================================================
  // set point storage option
  always_ff @(posedge clk) begin
    if (srst) begin
      setpoint_autosave_enable_r <= RST_AUTOSAVE;
    end else begin
      if (wr_to(req, IDX_AUTOSAVE) && req.wdata[15:0] <= SAVE_AUTO) begin
        setpoint_autosave_enable_r <= req.wdata[15:0];
      end
    end
  end

  // =====================================================================
  // calibration table
  always_ff @(posedge clk) begin
    if (srst) begin
      calibration_table_select_r <= RST_CAL;
    end else begin
      if (wr_to(req, IDX_CAL_SELECT) && req.wdata[15:0] < CAL_TABLES) begin
        calibration_table_select_r <= req.wdata[15:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cal_table <= 4'd0;
    end else begin
      cal_table <= calibration_table_select_r[3:0];
    end
  end

  // =====================================================================
  // flow set point
  always_ff @(posedge clk) begin
    if (srst) begin
      flow_target_r <= RST_WORD;
    end else begin
      if (wr_to(req, IDX_FLOW_TARGET)) begin
        flow_target_r <= req.wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      digital_src_r <= 1'b0;
    end else begin
      if (wr_to(req, IDX_FLOW_TARGET) && ctrl_mode_r == MODE_AUTO_SRC) begin
        digital_src_r <= 1'b1;
      end else if (wr_to(req, IDX_CTRL_MODE)) begin
        digital_src_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      nv_store_pulse <= 1'b0;
    end else begin
      nv_store_pulse <= wr_to(req, IDX_FLOW_TARGET)
                        && ctrl_mode_r == MODE_DIGITAL
                        && setpoint_autosave_enable_r == SAVE_AUTO;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      target_out   <= RST_WORD;
      target_valid <= 1'b0;
    end else begin
      // active in mode 1, or in mode 0 after a set point write
      if (ctrl_mode_r == MODE_DIGITAL
          || (ctrl_mode_r == MODE_AUTO_SRC && digital_src_r)) begin
        target_out   <= flow_target_r;
        target_valid <= 1'b1;
      end else begin
        target_valid <= 1'b0;
      end
    end
  end

  // =====================================================================
  // backup commands
  always_ff @(posedge clk) begin
    if (srst) begin
      dev_reset_pulse <= 1'b0;
      startup_op      <= BK_NONE;
      backup_exists   <= 1'b0;
    end else begin
      dev_reset_pulse <= 1'b0;
      if (wr_to(req, IDX_BACKUP_CMD)) begin
        case (req.wdata)
          CMD_BACKUP: begin
            startup_op      <= BK_BACKUP;
            dev_reset_pulse <= 1'b1;
            backup_exists   <= 1'b1;
          end
          CMD_RESTORE: begin
            if (backup_exists) begin
              startup_op      <= BK_RESTORE;
              dev_reset_pulse <= 1'b1;
            end
          end
          CMD_REMOVE: begin
            startup_op    <= BK_REMOVE;
            backup_exists <= 1'b0;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // =====================================================================
  // hardware fault flags
  always_ff @(posedge clk) begin
    if (srst) begin
      suppress_r <= '0;
    end else begin
      if (wr_to(req, IDX_ERR_ACK)) begin
        suppress_r <= suppress_r | req.wdata[FAULT_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fault_flags <= '0;
    end else begin
      if (wr_to(req, IDX_ERR_ACK)) begin
        fault_flags <= (fault_flags & ~req.wdata[FAULT_W-1:0])
                     | (fault_detect & ~suppress_r
                        & ~req.wdata[FAULT_W-1:0]);
      end else begin
        fault_flags <= fault_flags | (fault_detect & ~suppress_r);
      end
    end
  end

  // =====================================================================
  // valve drive
  always_comb begin
    if (ctrl_mode_r == MODE_VALVE_MAN) begin
      valve_nxt = valve_buf_r;
    end else begin
      valve_nxt = loop_valve;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      valve_buf_r  <= RST_WORD;
      valve_out    <= RST_WORD;
      valve_manual <= 1'b0;
    end else begin
      if (wr_to(req, IDX_VALVE_DRIVE)) begin
        valve_buf_r <= clip_valve(req.wdata);
      end
      if (ctrl_mode_r == MODE_VALVE_MAN && wr_to(req, IDX_VALVE_DRIVE)) begin
        valve_out <= clip_valve(req.wdata);
      end else begin
        valve_out <= valve_nxt;
      end
      valve_manual <= (ctrl_mode_r == MODE_VALVE_MAN);
    end
  end

  // =====================================================================
  // accumulated flow and read back
  always_ff @(posedge clk) begin
    if (srst) begin
      accum_r <= RST_WORD;
    end else if (wr_to(req, IDX_ACCUM_FLOW)) begin
      accum_r <= req.wdata;
    end else begin
      accum_r <= accum_in;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd && !wr_hit;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= RST_WORD;
    end else begin
      case (req.idx)
        IDX_FLOW_PSET:   rdata <= {16'h0000, flow_param_set_select_r};
        IDX_AUTOSAVE:    rdata <= {16'h0000, setpoint_autosave_enable_r};
        IDX_PRESS_PSET:  rdata <= {16'h0000, pressure_param_set_select_r};
        IDX_ACCUM_FLOW:  rdata <= accum_r;
        IDX_FLOW_TARGET: rdata <= flow_target_r;
        IDX_CAL_SELECT:  rdata <= {16'h0000, calibration_table_select_r};
        IDX_VALVE_DRIVE: rdata <= valve_out;
        IDX_CTRL_MODE:   rdata <= {16'h0000, ctrl_mode_r};
        IDX_FAULT_FLAGS: rdata <= 32'(fault_flags);
        default:         rdata <= RST_WORD;
      endcase
    end
  end

endmodule

`default_nettype wire

// ===== test/pdo_regs_checker.sv
`timescale 1ns/1ns
`default_nettype none
module pdo_regs_checker
  import pdo_regs_pkg::*;
#(
  parameter int unsigned FAULT_W = 16
) (
  input wire logic               clk,
  input wire logic               srst,
  input wire reg_req_t           req,
  input wire logic [FAULT_W-1:0] fault_detect,
  input wire logic [31:0]        loop_valve,
  input wire logic [2:0]         flow_pset,
  input wire logic [31:0]        valve_out,
  input wire logic               valve_manual,
  input wire logic               dev_reset_pulse,
  input wire backup_op_t         startup_op,
  input wire logic               backup_exists,
  input wire logic [FAULT_W-1:0] fault_flags
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic bk_wr;
  logic ack_wr;
  assign bk_wr = req.wr && req.idx == IDX_BACKUP_CMD;
  assign ack_wr = req.wr && req.idx == IDX_ERR_ACK;
  // ========
  // assertions
  chk_backup_reset: assert property (bk_wr && req.wdata == CMD_BACKUP
    |=> dev_reset_pulse && startup_op == BK_BACKUP && backup_exists)
    else $error("backup command did not reset");
  chk_restore_reset: assert property (bk_wr && req.wdata == CMD_RESTORE
    && backup_exists |=> dev_reset_pulse && startup_op == BK_RESTORE)
    else $error("restore command did not reset");
  chk_other_quiet: assert property (bk_wr && req.wdata != CMD_BACKUP
    && req.wdata != CMD_RESTORE |=> !dev_reset_pulse)
    else $error("reset from other backup code");
  chk_fault_cause: assert property (((fault_flags & ~$past(fault_flags))
    & ~$past(fault_detect)) == '0)
    else $error("fault bit set without detection");
  chk_ack_clear: assert property (ack_wr
    |=> (fault_flags & $past(req.wdata[FAULT_W-1:0])) == '0)
    else $error("acknowledged bit not cleared");
  chk_ack_keep: assert property (ack_wr |=> ($past(fault_flags)
    & ~$past(req.wdata[FAULT_W-1:0]) & ~fault_flags) == '0)
    else $error("unacknowledged bit lost");
  chk_valve_manual: assert property (valve_manual && req.wr
    && req.idx == IDX_VALVE_DRIVE && req.wdata <= VALVE_FULL
    && !$past(req.wr && req.idx == IDX_CTRL_MODE)
    |=> valve_out == $past(req.wdata))
    else $error("manual valve write not applied");
  chk_valve_loop: assert property (!$past(srst) && !$past(valve_manual)
    && !valve_manual |-> valve_out == $past(loop_valve))
    else $error("valve does not follow loop");
  chk_valve_range: assert property (valve_manual
    |-> valve_out <= VALVE_FULL)
    else $error("valve beyond full travel");
  chk_pset_apply: assert property (req.wr && req.idx == IDX_FLOW_PSET
    && req.wdata <= 32'h0000_0004 |-> ##2 flow_pset == $past(req.wdata[2:0], 2))
    else $error("set selector not applied");
  cover property (bk_wr && req.wdata == CMD_BACKUP);
  cover property (ack_wr && fault_flags != '0);
  cover property (valve_manual && req.wr && req.idx == IDX_VALVE_DRIVE);
endmodule
bind pdo_regs pdo_regs_checker #(.FAULT_W(FAULT_W)) chk_i (.clk, .srst, .req,
  .fault_detect, .loop_valve, .flow_pset, .valve_out, .valve_manual,
  .dev_reset_pulse, .startup_op, .backup_exists, .fault_flags);
`default_nettype wire

// ===== test/pdo_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module pdo_ctrl_model
  import pdo_regs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [31:0] rdata,
  input  wire logic        rvalid,
  output var reg_req_t     req
);
  initial req = '0;
  // released lines show the inverse of the last value
  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, idx: idx, wdata: d};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, idx: ~idx, wdata: ~d};
  endtask
  task automatic rd(input logic [3:0] idx, output logic [31:0] d);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, idx: idx, wdata: req.wdata};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, idx: ~idx, wdata: ~req.wdata};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      if (rvalid === 1'b1) break;
    end
    d = (rvalid === 1'b1) ? rdata : 'x;
  endtask
endmodule
`default_nettype wire

// ===== test/tb_pdo_regs.sv
`timescale 1ns/1ns
`default_nettype none
module tb_pdo_regs;
  import pdo_regs_pkg::*;
  logic        clk, srst, rvalid, target_valid, nv_store_pulse;
  logic        valve_manual, dev_reset_pulse, backup_exists;
  reg_req_t    req;
  logic [31:0] rdata, loop_valve, accum_in, target_out, valve_out, d;
  logic [15:0] fault_detect, fault_flags;
  logic [2:0]  flow_pset, press_pset;
  logic [3:0]  cal_table;
  backup_op_t  startup_op;
  int          n_fail, samples_checked, n_nv, n_rst, cycles;
  pdo_regs pdo_regs_i (.clk, .srst, .req, .rdata, .rvalid, .fault_detect,
    .loop_valve, .accum_in, .flow_pset, .press_pset, .cal_table, .target_out,
    .target_valid, .nv_store_pulse, .valve_out, .valve_manual,
    .dev_reset_pulse, .startup_op, .backup_exists, .fault_flags);
  pdo_ctrl_model pdo_ctrl_model_i (.clk, .rdata, .rvalid, .req);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (nv_store_pulse === 1'b1) n_nv++;
    if (dev_reset_pulse === 1'b1) n_rst++;
    if (cycles == 4000) begin
      n_fail++;
      conclude();
    end
  end
  // ========
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic w(input logic [3:0] idx, input logic [31:0] v);
    pdo_ctrl_model_i.wr(idx, v);
  endtask
  task automatic rchk(input logic [3:0] idx, input logic [31:0] exp);
    pdo_ctrl_model_i.rd(idx, d);
    chk(d, exp);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ========
  // tests
  initial begin
    srst = 1'b1;
    fault_detect = '0;
    loop_valve = 32'h0000_04D2;
    accum_in = 32'h0000_1234;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rchk(IDX_FLOW_PSET, {16'h0000, RST_PSET});
    rchk(IDX_CTRL_MODE, {16'h0000, RST_MODE});
    rchk(IDX_BACKUP_CMD, 32'h0000_0000);
    rchk(4'hF, 32'h0000_0000);
    rchk(IDX_ACCUM_FLOW, accum_in);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      w(IDX_FLOW_PSET, 32'(i));
      w(IDX_PRESS_PSET, 32'(i));
      settle();
      chk({29'h0, flow_pset}, 32'(i < 5 ? i : 4));
      chk({29'h0, press_pset}, 32'(i < 5 ? i : 4));
    end
    w(IDX_CAL_SELECT, 32'h0000_0009);
    w(IDX_CAL_SELECT, 32'h0000_000A);
    settle();
    chk({28'h0, cal_table}, 32'h0000_0009);
    rchk(IDX_CAL_SELECT, 32'h0000_0009);
    $display("test selectors done");
    w(IDX_FLOW_TARGET, 32'h0000_0064);
    settle();
    chk({31'h0, target_valid}, 32'h0000_0000);
    w(IDX_AUTOSAVE, {16'h0000, SAVE_AUTO});
    w(IDX_CTRL_MODE, {16'h0000, MODE_AUTO_SRC});
    settle();
    chk({31'h0, target_valid}, 32'h0000_0000);
    w(IDX_FLOW_TARGET, 32'h0000_0064);
    settle();
    chk({31'h0, target_valid}, 32'h0000_0001);
    chk(32'(n_nv), 32'h0000_0000);
    w(IDX_CTRL_MODE, {16'h0000, MODE_DIGITAL});
    w(IDX_FLOW_TARGET, 32'h0000_00C8);
    settle();
    chk(target_out, 32'h0000_00C8);
    chk(32'(n_nv), 32'h0000_0001);
    w(IDX_AUTOSAVE, 32'h0000_0002);
    rchk(IDX_AUTOSAVE, {16'h0000, SAVE_AUTO});
    w(IDX_AUTOSAVE, {16'h0000, SAVE_MANUAL});
    w(IDX_FLOW_TARGET, 32'h0000_012C);
    settle();
    chk(32'(n_nv), 32'h0000_0001);
    $display("test target done");
    // restore before any backup, on purpose
    w(IDX_BACKUP_CMD, CMD_RESTORE);
    settle();
    chk(32'(n_rst), 32'h0000_0000);
    w(IDX_BACKUP_CMD, CMD_BACKUP);
    settle();
    chk(32'(n_rst), 32'h0000_0001);
    chk({30'h0, startup_op}, {30'h0, BK_BACKUP});
    chk({31'h0, backup_exists}, 32'h0000_0001);
    w(IDX_BACKUP_CMD, 32'h0000_0007);
    settle();
    chk(32'(n_rst), 32'h0000_0001);
    w(IDX_BACKUP_CMD, CMD_RESTORE);
    settle();
    chk(32'(n_rst), 32'h0000_0002);
    chk({30'h0, startup_op}, {30'h0, BK_RESTORE});
    w(IDX_BACKUP_CMD, CMD_REMOVE);
    settle();
    chk(32'(n_rst), 32'h0000_0002);
    chk({31'h0, backup_exists}, 32'h0000_0000);
    chk({30'h0, startup_op}, {30'h0, BK_REMOVE});
    $display("test backup done");
    fault_detect <= 16'h0005;
    @(posedge clk);
    fault_detect <= 16'h0000;
    settle();
    rchk(IDX_FAULT_FLAGS, 32'h0000_0005);
    w(IDX_ERR_ACK, 32'h0000_0001);
    settle();
    chk({16'h0, fault_flags}, 32'h0000_0004);
    fault_detect <= 16'h0001;
    settle();
    chk({16'h0, fault_flags}, 32'h0000_0004);
    w(IDX_FAULT_FLAGS, 32'h0000_FFFF);
    fault_detect <= 16'h0000;
    settle();
    rchk(IDX_FAULT_FLAGS, 32'h0000_0004);
    $display("test faults done");
    loop_valve <= 32'h0000_0929;
    w(IDX_VALVE_DRIVE, 32'h0000_01F4);
    settle();
    chk(valve_out, 32'h0000_0929);
    rchk(IDX_VALVE_DRIVE, 32'h0000_0929);
    w(IDX_CTRL_MODE, {16'h0000, MODE_VALVE_MAN});
    settle();
    chk(valve_out, 32'h0000_01F4);
    chk({31'h0, valve_manual}, 32'h0000_0001);
    w(IDX_VALVE_DRIVE, 32'h0000_0BB8);
    settle();
    chk(valve_out, 32'h0000_0BB8);
    w(IDX_VALVE_DRIVE, 32'h0000_4E20);
    settle();
    chk(valve_out, VALVE_FULL);
    rchk(IDX_VALVE_DRIVE, VALVE_FULL);
    $display("test valve done");
    conclude();
  end
endmodule
`default_nettype wire
